// ==== core/adc_regs_pkg.sv ====
// Purpose : constants, field layout and encodings of the converter register block
// Assumes : byte-wide registers on an 8-bit address, single bus clock
// Notes   : shared by the register block and the clock generator

package adc_regs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned DIVCNT_W = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS_CTRL2 = 8'h31;
  localparam logic [7:0] OFF_RESULT_HIGH  = 8'h32;
  localparam logic [7:0] OFF_RESULT_LOW   = 8'h33;
  localparam logic [7:0] OFF_COMPARE_HIGH = 8'h34;
  localparam logic [7:0] OFF_COMPARE_LOW  = 8'h35;
  localparam logic [7:0] OFF_CONFIG       = 8'h36;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SC2_ACTIVE_BIT   = 7;
  localparam int unsigned SC2_CMP_EN_BIT   = 5;
  localparam int unsigned SC2_CMP_GT_BIT   = 4;
  localparam int unsigned SC2_REF_HI       = 1;
  localparam int unsigned SC2_REF_LO       = 0;
  localparam int unsigned CFG_LOW_POWER    = 7;
  localparam int unsigned CFG_DIV_HI       = 6;
  localparam int unsigned CFG_DIV_LO       = 5;
  localparam int unsigned CFG_LONG_SAMPLE  = 4;
  localparam int unsigned CFG_MODE_HI      = 3;
  localparam int unsigned CFG_MODE_LO      = 2;
  localparam int unsigned CFG_CLKSRC_HI    = 1;
  localparam int unsigned CFG_CLKSRC_LO    = 0;
  localparam int unsigned VALUE_HIGH_MSB   = 11;
  localparam int unsigned VALUE_HIGH_LSB   = 8;
  localparam int unsigned VALUE_LOW_MSB    = 7;

  // ----------------------------------------------------------------
  // reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [3:0]  NIBBLE_ZERO   = 4'h0;
  localparam logic [11:0] RESULT_RESET  = 12'h000;
  localparam logic [11:0] COMPARE_RESET = 12'h000;
  localparam logic [1:0]  CODE_ZERO     = 2'h0;
  localparam logic [1:0]  CODE_DIV8     = 2'h3;
  localparam logic [2:0]  ROUTE_PINS    = 3'h1;
  localparam logic [2:0]  ROUTE_SUPPLY  = 3'h2;
  localparam logic [2:0]  ROUTE_BANDGAP = 3'h4;
  localparam logic [3:0]  RES_BITS_8    = 4'h8;
  localparam logic [3:0]  RES_BITS_10   = 4'ha;
  localparam logic [3:0]  RES_BITS_12   = 4'hc;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {REF_PINS_A, REF_SUPPLY, REF_BANDGAP, REF_PINS_B} reference_select_t;
  typedef enum logic [1:0] {CLK_BUS, CLK_BUS_HALF, CLK_OFF_CHIP, CLK_INTERNAL} clock_source_t;
  typedef enum logic [1:0] {RES_8BIT, RES_12BIT, RES_10BIT_A, RES_10BIT_B} resolution_t;

endpackage

// ==== core/result_compare.sv ====
// Purpose : magnitude match of a conversion outcome against the compare value
// Assumes : operands are stable in the cycle the match is used
// Notes   : purely combinational, the caller registers what it needs
`timescale 1ns/10ps

module result_compare
(
  input  wire logic [11:0] sample_i,
  input  wire logic [11:0] compare_value_i,
  input  wire logic        greater_i,
  output logic             match_o
);

  // ----------------------------------------------------------------
  // match criterion
  // ----------------------------------------------------------------
  // greater mode matches above the value, less mode below it
  always_comb
  begin
    if (greater_i)
    begin
      match_o = (sample_i > compare_value_i);
    end
    else
    begin
      match_o = (sample_i < compare_value_i);
    end
  end

endmodule // result_compare

// ==== core/conv_clock_gen.sv ====
// Purpose : conversion clock enable from the chosen source and divide ratio
// Assumes : off-chip and internal clocks are far slower than the bus clock
// Notes   : outside clocks are sampled, the tick is a bus-clock enable pulse
`timescale 1ns/10ps

module conv_clock_gen
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] source_i,
  input  wire logic [1:0] divide_i,
  input  wire logic       ext_clk_i,
  input  wire logic       async_clk_i,
  output logic            tick_o
);

  logic [1:0] pin_raw;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;
  logic [1:0] level_r;
  logic [1:0] rise;
  logic       half_r;
  logic       src_tick;
  logic [2:0] limit;
  logic [2:0] cnt_r;
  logic       tick_r;

  assign pin_raw = {async_clk_i, ext_clk_i};

  // ----------------------------------------------------------------
  // three-stage sampling of the outside clocks
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_pin
      // a level counts once stages two and three agree
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          sync3_r[g] <= 1'b0;
          level_r[g] <= 1'b0;
        end
        else
        begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
          if (sync2_r[g] == sync3_r[g])
          begin
            level_r[g] <= sync2_r[g];
          end
        end
      end
      assign rise[g] = (sync2_r[g] == sync3_r[g]) && sync2_r[g] && !level_r[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // half-rate toggle for the divided bus clock
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      half_r <= 1'b0;
    end
    else
    begin
      half_r <= !half_r;
    end
  end

  // one enable per source clock period
  always_comb
  begin
    case (adc_regs_pkg::clock_source_t'(source_i))
      adc_regs_pkg::CLK_BUS:      src_tick = 1'b1;
      adc_regs_pkg::CLK_BUS_HALF: src_tick = half_r;
      adc_regs_pkg::CLK_OFF_CHIP: src_tick = rise[0];
      adc_regs_pkg::CLK_INTERNAL: src_tick = rise[1];
      default:                    src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // divider by 1, 2, 4 or 8
  // ----------------------------------------------------------------
  assign limit = 3'((4'h1 << divide_i) - 4'h1);

  // counts source ticks, fires when the ratio is reached
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= 3'h0;
      tick_r <= 1'b0;
    end
    else if (src_tick && (cnt_r >= limit))
    begin
      cnt_r  <= 3'h0;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= src_tick ? 3'(cnt_r + 3'h1) : cnt_r;
      tick_r <= 1'b0;
    end
  end

  assign tick_o = tick_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_div_eight_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tick_o && divide_i == adc_regs_pkg::CODE_DIV8) |=>
    (!tick_o || divide_i != adc_regs_pkg::CODE_DIV8) [*7])
    else $error("divide by eight ticked early");

  a_div_one_rate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (source_i == adc_regs_pkg::CODE_ZERO && divide_i == adc_regs_pkg::CODE_ZERO) [*2]
    |-> tick_o)
    else $error("divide by one missed a tick");

  a_half_rate_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tick_o && source_i == 2'h1 && divide_i == adc_regs_pkg::CODE_ZERO) |=> !tick_o)
    else $error("half bus clock ticked back to back");

endmodule // conv_clock_gen

// ==== core/adc_regs.sv ====
// Purpose : register side of the successive-approximation converter
// Assumes : conversion done pulse and result come from logic on sys_clk_i
// Notes   : plain strobe bus, read data stand only in the cycle after the strobe
// Function
// - reference code 00/11 pins, 01 analog supply, 10 band gap
// - 12-bit result: bits 11:8 in high byte low nibble, 7:0 low byte
// - both result bytes are read-only; writes change nothing
// - result loads from the successive-approximation output, zero after reset
// - compare bytes are read/write, reset to zero; low reads back last write, high only bits 3:0 of it
// - compare high write updates only bits 11:8 from data bits 3:0
// - compare low write updates bits 7:0, keeps bits 11:8
// - compare mode matches each outcome against the stored compare value
// - config bit 7 selects normal power (0) or low power (1)
// - config bits 6:5 divide converter clock by 1, 2, 4, 8
// - config bit 4 selects short (0) or long (1) sample phase
// - compare enable 0 normal conversions, 1 compare conversions, reset 0
// - resolution 00 8-bit, 01 12-bit, 10 and 11 10-bit
// - clock source bus, bus half, off-chip or internal asynchronous
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps

module adc_regs
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [11:0] sar_result_i,
  input  wire logic        sar_done_i,
  input  wire logic        sar_active_i,
  input  wire logic        ext_clk_i,
  input  wire logic        async_clk_i,
  output logic             ref_pins_o,
  output logic             ref_supply_o,
  output logic             ref_bandgap_o,
  output logic             compare_enable_o,
  output logic             compare_greater_o,
  output logic      [11:0] compare_value_o,
  output logic             compare_match_o,
  output logic             low_power_o,
  output logic             long_sample_o,
  output logic      [3:0]  res_bits_o,
  output logic             conv_tick_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // address match against one register offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // reference code to one-hot route {band gap, supply, pins}
  function automatic logic [2:0] ref_route(input logic [1:0] code);
    case (adc_regs_pkg::reference_select_t'(code))
      adc_regs_pkg::REF_SUPPLY:  ref_route = adc_regs_pkg::ROUTE_SUPPLY;
      adc_regs_pkg::REF_BANDGAP: ref_route = adc_regs_pkg::ROUTE_BANDGAP;
      default:                   ref_route = adc_regs_pkg::ROUTE_PINS;
    endcase
  endfunction

  // resolution code to result width
  function automatic logic [3:0] res_width(input logic [1:0] code);
    case (adc_regs_pkg::resolution_t'(code))
      adc_regs_pkg::RES_8BIT:  res_width = adc_regs_pkg::RES_BITS_8;
      adc_regs_pkg::RES_12BIT: res_width = adc_regs_pkg::RES_BITS_12;
      default:                 res_width = adc_regs_pkg::RES_BITS_10;
    endcase
  endfunction

  logic        wr_sc2;
  logic        wr_cmp_high;
  logic        wr_cmp_low;
  logic        wr_cfg;
  logic [1:0]  ref_code_r;
  logic [2:0]  route_r;
  logic        cmp_en_r;
  logic        cmp_gt_r;
  logic [7:0]  cfg_r;
  logic [3:0]  res_bits_r;
  logic [11:0] result_r;
  logic [11:0] compare_r;
  logic        match;
  logic        load_result;
  logic        match_r;
  logic [7:0]  rd_mux;
  logic [7:0]  rdata_r;

  assign wr_sc2      = wr_i && reg_hit(addr_i, adc_regs_pkg::OFF_STATUS_CTRL2);
  assign wr_cmp_high = wr_i && reg_hit(addr_i, adc_regs_pkg::OFF_COMPARE_HIGH);
  assign wr_cmp_low  = wr_i && reg_hit(addr_i, adc_regs_pkg::OFF_COMPARE_LOW);
  assign wr_cfg      = wr_i && reg_hit(addr_i, adc_regs_pkg::OFF_CONFIG);

  // ----------------------------------------------------------------
  // status and control two: compare mode and reference
  // ----------------------------------------------------------------
  // reference code and its registered route
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ref_code_r <= adc_regs_pkg::CODE_ZERO;
      route_r    <= adc_regs_pkg::ROUTE_PINS;
    end
    else if (wr_sc2)
    begin
      ref_code_r <= wdata_i[adc_regs_pkg::SC2_REF_HI:adc_regs_pkg::SC2_REF_LO];
      route_r    <= ref_route(wdata_i[adc_regs_pkg::SC2_REF_HI:adc_regs_pkg::SC2_REF_LO]);
    end
  end

  // compare enable and direction
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cmp_en_r <= 1'b0;
      cmp_gt_r <= 1'b0;
    end
    else if (wr_sc2)
    begin
      cmp_en_r <= wdata_i[adc_regs_pkg::SC2_CMP_EN_BIT];
      cmp_gt_r <= wdata_i[adc_regs_pkg::SC2_CMP_GT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  // whole byte writable, fields fan out below
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cfg_r      <= adc_regs_pkg::BYTE_ZERO;
      res_bits_r <= adc_regs_pkg::RES_BITS_8;
    end
    else if (wr_cfg)
    begin
      cfg_r      <= wdata_i;
      res_bits_r <= res_width(wdata_i[adc_regs_pkg::CFG_MODE_HI:adc_regs_pkg::CFG_MODE_LO]);
    end
  end

  // ----------------------------------------------------------------
  // compare value
  // ----------------------------------------------------------------
  // each byte write touches only its own part of the value
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      compare_r <= adc_regs_pkg::COMPARE_RESET;
    end
    else if (wr_cmp_high)
    begin
      compare_r[adc_regs_pkg::VALUE_HIGH_MSB:adc_regs_pkg::VALUE_HIGH_LSB] <=
        wdata_i[adc_regs_pkg::NIBBLE_W-1:0];
    end
    else if (wr_cmp_low)
    begin
      compare_r[adc_regs_pkg::VALUE_LOW_MSB:0] <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // result capture
  // ----------------------------------------------------------------
  result_compare u_compare
  (
    .sample_i        (sar_result_i),
    .compare_value_i (compare_r),
    .greater_i       (cmp_gt_r),
    .match_o         (match)
  );

  // in compare mode only a matching outcome is kept
  assign load_result = sar_done_i && (!cmp_en_r || match);

  // loads from the converter only, never from the bus
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      result_r <= adc_regs_pkg::RESULT_RESET;
    end
    else if (load_result)
    begin
      result_r <= sar_result_i;
    end
  end

  // one-cycle pulse for a matching compare conversion
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      match_r <= 1'b0;
    end
    else
    begin
      match_r <= sar_done_i && cmp_en_r && match;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped offsets and unused bits read as zero
  always_comb
  begin
    rd_mux = adc_regs_pkg::BYTE_ZERO;
    case (1'b1)
      reg_hit(addr_i, adc_regs_pkg::OFF_STATUS_CTRL2):
      begin
        rd_mux[adc_regs_pkg::SC2_ACTIVE_BIT] = sar_active_i;
        rd_mux[adc_regs_pkg::SC2_CMP_EN_BIT] = cmp_en_r;
        rd_mux[adc_regs_pkg::SC2_CMP_GT_BIT] = cmp_gt_r;
        rd_mux[adc_regs_pkg::SC2_REF_HI:adc_regs_pkg::SC2_REF_LO] = ref_code_r;
      end
      reg_hit(addr_i, adc_regs_pkg::OFF_RESULT_HIGH):
        rd_mux = {adc_regs_pkg::NIBBLE_ZERO, result_r[11:8]};
      reg_hit(addr_i, adc_regs_pkg::OFF_RESULT_LOW):
        rd_mux = result_r[adc_regs_pkg::VALUE_LOW_MSB:0];
      reg_hit(addr_i, adc_regs_pkg::OFF_COMPARE_HIGH):
        rd_mux = {adc_regs_pkg::NIBBLE_ZERO, compare_r[11:8]};
      reg_hit(addr_i, adc_regs_pkg::OFF_COMPARE_LOW):
        rd_mux = compare_r[adc_regs_pkg::VALUE_LOW_MSB:0];
      reg_hit(addr_i, adc_regs_pkg::OFF_CONFIG):
        rd_mux = cfg_r;
      default:
        rd_mux = adc_regs_pkg::BYTE_ZERO;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_r <= adc_regs_pkg::BYTE_ZERO;
    end
    else
    begin
      rdata_r <= rd_i ? rd_mux : adc_regs_pkg::BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------
  conv_clock_gen u_clock
  (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .source_i    (cfg_r[adc_regs_pkg::CFG_CLKSRC_HI:adc_regs_pkg::CFG_CLKSRC_LO]),
    .divide_i    (cfg_r[adc_regs_pkg::CFG_DIV_HI:adc_regs_pkg::CFG_DIV_LO]),
    .ext_clk_i   (ext_clk_i),
    .async_clk_i (async_clk_i),
    .tick_o      (conv_tick_o)
  );

  // ----------------------------------------------------------------
  // outputs to the converter core
  // ----------------------------------------------------------------
  assign rdata_o           = rdata_r;
  assign ref_pins_o        = route_r[0];
  assign ref_supply_o      = route_r[1];
  assign ref_bandgap_o     = route_r[2];
  assign compare_enable_o  = cmp_en_r;
  assign compare_greater_o = cmp_gt_r;
  assign compare_value_o   = compare_r;
  assign compare_match_o   = match_r;
  assign low_power_o       = cfg_r[adc_regs_pkg::CFG_LOW_POWER];
  assign long_sample_o     = cfg_r[adc_regs_pkg::CFG_LONG_SAMPLE];
  assign res_bits_o        = res_bits_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ref_pins_alias: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_sc2 && wdata_i[1:0] == 2'h3) |=> (ref_pins_o && !ref_supply_o && !ref_bandgap_o))
    else $error("code 11 did not route the reference pins");

  a_ref_bandgap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_sc2 && wdata_i[1:0] == 2'h2) |=> (ref_bandgap_o && !ref_pins_o && !ref_supply_o))
    else $error("code 10 did not route the band gap");

  a_read_result_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i == adc_regs_pkg::OFF_RESULT_HIGH) |=>
    (rdata_o == {4'h0, $past(result_r[11:8])}))
    else $error("result high byte read wrong");

  a_result_read_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && (addr_i == adc_regs_pkg::OFF_RESULT_HIGH || addr_i == adc_regs_pkg::OFF_RESULT_LOW)
     && !sar_done_i) |=> $stable(result_r))
    else $error("bus write changed the result");

  a_result_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sar_done_i && !cmp_en_r) |=> (result_r == $past(sar_result_i)))
    else $error("completed conversion not captured");

  a_reset_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (result_r == 12'h000 && compare_r == 12'h000 && !compare_enable_o))
    else $error("registers not zero after reset");

  a_cmp_high_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_cmp_high |=> (compare_r[11:8] == $past(wdata_i[3:0]) &&
                     compare_r[7:0] == $past(compare_r[7:0])))
    else $error("compare high write wrong");

  a_cmp_low_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_cmp_low |=> (compare_r[7:0] == $past(wdata_i) &&
                    compare_r[11:8] == $past(compare_r[11:8])))
    else $error("compare low write wrong");

  a_cmp_no_match_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sar_done_i && cmp_en_r && !cmp_gt_r && sar_result_i >= compare_r) |=>
    ($stable(result_r) && !compare_match_o))
    else $error("non-matching compare outcome kept");

  a_cfg_power_sample: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_cfg |=> (low_power_o == $past(wdata_i[7]) && long_sample_o == $past(wdata_i[4])))
    else $error("power or sample select wrong");

  a_mode_ten_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_cfg && wdata_i[3:2] == 2'h3) |=> (res_bits_o == 4'ha))
    else $error("mode 11 is not 10-bit");

  a_result_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sar_done_i |=> $stable(result_r))
    else $error("result changed without a completion");

  c_compare_match: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    compare_match_o);

  c_write_then_read: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_cmp_high ##1 (rd_i && addr_i == adc_regs_pkg::OFF_COMPARE_HIGH));

  c_load_then_read: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    load_result ##[1:20] (rd_i && addr_i == adc_regs_pkg::OFF_RESULT_LOW));

endmodule // adc_regs

// ==== verif/adc_regs_tb.sv ====
// Purpose : self-checking bench of the converter register block
// Assumes : outside conversion clocks run from a bench counter, converter never busy
// Notes   : config cases run from a table, the rest by hand
`timescale 1ns/10ps

module adc_regs_tb;
  typedef struct {logic [7:0] d; logic [3:0] res;} row_t;
  logic        sys_clk_i, rst_i, wr_i, rd_i, sar_done_i, tick_o;
  logic        pins_o, sup_o, bg_o, match_o, lp_o, ls_o, cen_o, cgt_o;
  logic [2:0]  pin_cnt = 3'h0;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [11:0] sar_result_i, cval_o;
  logic [3:0]  res_o;
  int          num_errors, checked, n;
  row_t        rows [6] = '{'{8'h80, 4'h8}, '{8'h10, 4'h8}, '{8'h04, 4'hc},
                            '{8'h08, 4'ha}, '{8'h0c, 4'ha}, '{8'h60, 4'h8}};

  adc_regs dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sar_result_i(sar_result_i), .sar_done_i(sar_done_i), .sar_active_i(1'b0),
    .ext_clk_i(pin_cnt[2]), .async_clk_i(pin_cnt[1]), .ref_pins_o(pins_o),
    .ref_supply_o(sup_o), .ref_bandgap_o(bg_o), .compare_enable_o(cen_o),
    .compare_greater_o(cgt_o), .compare_value_o(cval_o), .compare_match_o(match_o),
    .low_power_o(lp_o), .long_sample_o(ls_o), .res_bits_o(res_o),
    .conv_tick_o(tick_o));

  // ------------------------------------------------------------
  // clock, compare and bus tasks
  // ------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // outside clocks: off-chip period 8 cycles, internal period 4 cycles
  always @(posedge sys_clk_i)
  begin
    pin_cnt <= 3'(pin_cnt + 3'h1);
  end

  task cmp(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // read data are looked at only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 cmp({4'h0, rdata_o}, {4'h0, e});
  endtask

  // one conversion done pulse, match pulse seen in the next cycle
  task conv(input logic [11:0] v, input logic m);
    @(posedge sys_clk_i);
    sar_result_i <= v;
    sar_done_i <= 1'b1;
    @(posedge sys_clk_i);
    sar_done_i <= 1'b0;
    #1 cmp({11'h0, match_o}, {11'h0, m});
  endtask

  task test_done;
    $display("Errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    #200000 num_errors++;
    test_done();
  end

  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sar_done_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    sar_result_i = 12'h000;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 cmp({pins_o, sup_o, bg_o, cen_o, cgt_o}, 12'h010);
    cmp({lp_o, ls_o, res_o}, 12'h008);
    for (int i = 8'h31; i <= 8'h36; i++) rd(i[7:0], 8'h00);
    foreach (rows[i])
    begin
      wr(8'h36, rows[i].d);
      cmp({lp_o, ls_o, res_o}, {rows[i].d[7], rows[i].d[4], rows[i].res});
      rd(8'h36, rows[i].d);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h31, i[7:0]);
      cmp({pins_o, sup_o, bg_o}, (i == 1) ? 3'h2 : (i == 2) ? 3'h1 : 3'h4);
    end
    // divide ratios on the bus clock, then bus half, off-chip and internal sources
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h36, (i < 4) ? {1'b0, i[1:0], 5'h00} : 8'(i - 3));
      repeat (10) @(posedge sys_clk_i);
      n = 0;
      repeat (32) @(posedge sys_clk_i) #1 n += int'(tick_o);
      cmp(n[11:0], (i < 4) ? 12'h020 >> i : (i == 4) ? 12'h010 : (i == 5) ? 12'h004 : 12'h008);
    end
    wr(8'h34, 8'ha5);
    cmp(cval_o, 12'h500);
    wr(8'h35, 8'h3c);
    cmp(cval_o, 12'h53c);
    rd(8'h34, 8'h05);
    rd(8'h35, 8'h3c);
    conv(12'h123, 1'b0);
    wr(8'h32, 8'hff);
    wr(8'h33, 8'hff);
    rd(8'h32, 8'h01);
    rd(8'h33, 8'h23);
    rd(8'h40, 8'h00);
    wr(8'h31, 8'h20);
    cmp({cen_o, cgt_o}, 12'h002);
    conv(12'h600, 1'b0);
    rd(8'h33, 8'h23);
    conv(12'h100, 1'b1);
    rd(8'h32, 8'h01);
    wr(8'h31, 8'h30);
    cmp({cen_o, cgt_o}, 12'h003);
    conv(12'h7ff, 1'b1);
    rd(8'h33, 8'hff);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 cmp({pins_o, sup_o, bg_o, cen_o, cgt_o}, 12'h010);
    cmp({lp_o, ls_o, res_o}, 12'h008);
    rd(8'h34, 8'h00);
    rd(8'h32, 8'h00);
    test_done();
  end
endmodule // adc_regs_tb
